// ---- rtl/pwe_pkg.sv ----
// Contract
// - seventeen lines pick one byte; hold during access
// - write needs select, write low, gate high
// - further page bytes use same write cycle
// - page bits 8 to 16 stay fixed
// - next write fall within 100 us
// - select from decode, shared gate and write
package pwe_pkg;
  localparam int CLK_NS = 5;
  localparam int LOC_W = 17;
  localparam int DATA_W = 8;
  localparam int PAGE_LSB = 8;
  localparam int PAGE_W = LOC_W - PAGE_LSB;
  localparam int PAGE_BYTES = 256;
  localparam int READ_NS = 250;
  localparam int READ_CYC = (READ_NS + CLK_NS - 1) / CLK_NS;
  localparam int FLOAT_NS = 50;
  localparam int FLOAT_CYC = (FLOAT_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_NS = 20;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int NOISE_NS = 10;
  localparam int PULSE_NS = 100;
  localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_NS = 20;
  localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOAD_NS = 100000;
  localparam int LOAD_CYC = LOAD_NS / CLK_NS;
  localparam int LOAD_MARGIN_CYC = SETUP_CYC + 2;
  localparam int PROG_NS = 10000000;
  localparam int PROG_CYC = (PROG_NS + CLK_NS - 1) / CLK_NS;

  typedef struct packed {
    logic write;
    logic [LOC_W-1:0] loc;
    logic [DATA_W-1:0] data;
  } pwe_req_s;

  typedef struct packed {
    logic [LOC_W-1:0] byte_location_lines;
    logic [DATA_W-1:0] byte_lane_out;
    logic byte_lane_oe_b;
    logic chip_sel_b;
    logic out_gate_b;
    logic wr_strobe_b;
  } pwe_pins_s;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RD = 6'h02,
    ST_FLOAT = 6'h04,
    ST_WSET = 6'h08,
    ST_WPULSE = 6'h10,
    ST_WHOLD = 6'h20
  } pwe_state_e;

  function automatic logic pwe_last(input logic [7:0] phase, input int n);
    pwe_last = (phase == 8'(n - 1));
  endfunction : pwe_last
endpackage : pwe_pkg

// ---- rtl/pwe_host.sv ----
`timescale 1ns/10ps
module pwe_host #(
  parameter int unsigned LOAD_CYC_P = pwe_pkg::LOAD_CYC,
  parameter int unsigned PROG_CYC_P = pwe_pkg::PROG_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic req_valid,
  input pwe_pkg::pwe_req_s req,
  output logic req_ready,
  output logic rd_valid,
  output logic [pwe_pkg::DATA_W-1:0] rd_data,
  output logic page_open,
  output pwe_pkg::pwe_pins_s pins,
  input wire logic [pwe_pkg::DATA_W-1:0] byte_lane_in
);
  import pwe_pkg::*;

  pwe_state_e state;
  logic [7:0] phase;
  logic [31:0] since_fall;
  logic [8:0] page_cnt;
  logic [PAGE_W-1:0] page_hi;
  logic window_ok;
  logic prog_done;
  logic fits;
  logic take;

  // a page takes more bytes only while it holds under 256 and the next write fall can still land inside the window
  assign window_ok = page_open && (since_fall + LOAD_MARGIN_CYC < LOAD_CYC_P)
                     && (page_cnt < 9'(PAGE_BYTES));
  assign prog_done = since_fall >= LOAD_CYC_P + PROG_CYC_P;
  assign fits = !page_open
                || (req.write && req.loc[LOC_W-1:PAGE_LSB] == page_hi && window_ok);
  assign take = (state == ST_IDLE) && req_valid && req_ready && fits;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= ST_IDLE;
      phase <= 8'h00;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          phase <= 8'h00;
          if (take)
            state <= req.write ? ST_WSET : ST_RD;
        end
        ST_RD:
        begin
          phase <= pwe_last(phase, READ_CYC) ? 8'h00 : phase + 8'h01;
          if (pwe_last(phase, READ_CYC))
            state <= ST_FLOAT;
        end
        ST_FLOAT:
        begin
          phase <= pwe_last(phase, FLOAT_CYC) ? 8'h00 : phase + 8'h01;
          if (pwe_last(phase, FLOAT_CYC))
            state <= ST_IDLE;
        end
        ST_WSET:
        begin
          phase <= pwe_last(phase, SETUP_CYC) ? 8'h00 : phase + 8'h01;
          if (pwe_last(phase, SETUP_CYC))
            state <= ST_WPULSE;
        end
        ST_WPULSE:
        begin
          phase <= pwe_last(phase, PULSE_CYC) ? 8'h00 : phase + 8'h01;
          if (pwe_last(phase, PULSE_CYC))
            state <= ST_WHOLD;
        end
        ST_WHOLD:
        begin
          phase <= pwe_last(phase, HOLD_CYC) ? 8'h00 : phase + 8'h01;
          if (pwe_last(phase, HOLD_CYC))
            state <= ST_IDLE;
        end
        default:
        begin
          state <= ST_IDLE;
          phase <= 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      req_ready <= 1'b0;
    else
      req_ready <= (state == ST_IDLE) && !take && (!page_open || window_ok || prog_done);
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pins.byte_location_lines <= '0;
      pins.byte_lane_out <= '0;
      pins.byte_lane_oe_b <= 1'b1;
      pins.chip_sel_b <= 1'b1;
      pins.out_gate_b <= 1'b1;
      pins.wr_strobe_b <= 1'b1;
    end
    else if (take)
    begin
      // address is set with select and held until the next request
      pins.byte_location_lines <= req.loc;
      pins.byte_lane_out <= req.data;
      pins.chip_sel_b <= 1'b0;
      pins.byte_lane_oe_b <= !req.write;
      pins.out_gate_b <= req.write;
    end
    else
    begin
      case (state)
        ST_RD:
          if (pwe_last(phase, READ_CYC))
          begin
            pins.chip_sel_b <= 1'b1;
            pins.out_gate_b <= 1'b1;
          end
        ST_WSET:
          if (pwe_last(phase, SETUP_CYC))
            pins.wr_strobe_b <= 1'b0;
        ST_WPULSE:
          if (pwe_last(phase, PULSE_CYC))
            pins.wr_strobe_b <= 1'b1;
        ST_WHOLD:
          if (pwe_last(phase, HOLD_CYC))
          begin
            pins.chip_sel_b <= 1'b1;
            pins.byte_lane_oe_b <= 1'b1;
          end
        default:
          pins.chip_sel_b <= pins.chip_sel_b;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_valid <= 1'b0;
      rd_data <= '0;
    end
    else
    begin
      rd_valid <= (state == ST_RD) && pwe_last(phase, READ_CYC);
      if ((state == ST_RD) && pwe_last(phase, READ_CYC))
        rd_data <= byte_lane_in;
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      since_fall <= 32'h0000_0000;
      page_open <= 1'b0;
      page_cnt <= 9'h000;
      page_hi <= '0;
    end
    else if ((state == ST_WSET) && pwe_last(phase, SETUP_CYC))
    begin
      since_fall <= 32'h0000_0000;
      page_open <= 1'b1;
      page_cnt <= page_open ? page_cnt + 9'h001 : 9'h001;
      if (!page_open)
        page_hi <= pins.byte_location_lines[LOC_W-1:PAGE_LSB];
    end
    else
    begin
      if (since_fall != 32'hFFFF_FFFF)
        since_fall <= since_fall + 32'h0000_0001;
      // the device finishes on its own; the page is only released after the worst case
      if (page_open && prog_done)
      begin
        page_open <= 1'b0;
        page_cnt <= 9'h000;
      end
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  property p_addr_hold;
    !pins.chip_sel_b && $past(!pins.chip_sel_b) |-> $stable(pins.byte_location_lines);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved during access");

  property p_read_gate;
    $rose(rd_valid) |-> $past(!pins.out_gate_b) && $past(!pins.chip_sel_b) && $past(pins.byte_lane_oe_b);
  endproperty
  a_read_gate: assert property (p_read_gate) else $error("read sampled without both strobes low");

  property p_no_drive_on_read;
    !pins.out_gate_b |-> pins.byte_lane_oe_b && pins.wr_strobe_b;
  endproperty
  a_no_drive_on_read: assert property (p_no_drive_on_read) else $error("lanes driven while gate low");

  property p_write_combo;
    !pins.wr_strobe_b |-> !pins.chip_sel_b && pins.out_gate_b && !pins.byte_lane_oe_b;
  endproperty
  a_write_combo: assert property (p_write_combo) else $error("write strobe low in wrong combination");

  property p_pulse_width;
    $fell(pins.wr_strobe_b) |-> !pins.wr_strobe_b [*8];
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("write pulse too short");

  property p_same_page;
    $fell(pins.wr_strobe_b) && page_cnt > 9'h001 |-> pins.byte_location_lines[LOC_W-1:PAGE_LSB] == page_hi;
  endproperty
  a_same_page: assert property (p_same_page) else $error("page bits changed inside a page");

  property p_load_window;
    $fell(pins.wr_strobe_b) && page_cnt > 9'h001 |-> $past(since_fall, 2) < LOAD_CYC_P;
  endproperty
  a_load_window: assert property (p_load_window) else $error("page byte loaded too late");

  property p_page_size;
    page_cnt <= 9'(PAGE_BYTES);
  endproperty
  a_page_size: assert property (p_page_size) else $error("page holds more than 256 bytes");

  property p_quiet_while_prog;
    page_open && since_fall >= LOAD_CYC_P && !prog_done |-> pins.chip_sel_b && take == 1'b0;
  endproperty
  a_quiet_while_prog: assert property (p_quiet_while_prog) else $error("access during programming");

  c_read: cover property ($rose(rd_valid));
  c_page_two: cover property ($fell(pins.wr_strobe_b) && page_cnt == 9'h002);
  c_prog_end: cover property ($fell(page_open));
endmodule : pwe_host

// ---- test/pwe_mem_model.sv ----
`timescale 1ns/10ps
module pwe_mem_model #(
  parameter int unsigned WIN_NS = 1000,
  parameter int unsigned PROG_NS = 1500
) (
  input pwe_pkg::pwe_pins_s pins,
  output logic [pwe_pkg::DATA_W-1:0] lanes,
  output int errs
);
  import pwe_pkg::*;
  logic [DATA_W-1:0] mem [logic [LOC_W-1:0]];
  logic [LOC_W-1:0] wloc;
  logic [PAGE_W-1:0] pg;
  logic [DATA_W-1:0] last = 8'h00;
  logic on = 1'b0;
  realtime t_fall = 0;
  realtime t_busy = 0;
  int n = 0;
  wire logic rd = !pins.chip_sel_b && !pins.out_gate_b && pins.wr_strobe_b;
  wire logic wr = !pins.chip_sel_b && !pins.wr_strobe_b && pins.out_gate_b;
  initial errs = 0;
  function automatic logic [DATA_W-1:0] peek(input logic [LOC_W-1:0] a);
    return mem.exists(a) ? mem[a] : a[7:0] ^ 8'hA5;
  endfunction : peek
  // a quiet window closes the page and starts self-timed programming
  task automatic touch();
    if (n > 0 && $realtime - t_fall > WIN_NS)
    begin
      t_busy = t_fall + WIN_NS + PROG_NS;
      n = 0;
    end
    if ($realtime < t_busy) errs++;
  endtask : touch
  // released lanes show the inverse of the last byte read, not a stale copy
  always_comb
  begin
    if (!pins.byte_lane_oe_b) lanes = pins.byte_lane_out;
    else if (rd) lanes = peek(pins.byte_location_lines);
    else lanes = ~last;
  end
  always @(posedge rd)
  begin
    touch();
    if (n > 0) errs++;
    last = peek(pins.byte_location_lines);
  end
  always @(posedge wr)
  begin
    touch();
    wloc = pins.byte_location_lines;
    if (n > 0 && wloc[LOC_W-1:PAGE_LSB] != pg) errs++;
    if (n == PAGE_BYTES) errs++;
    if (n == 0) pg = wloc[LOC_W-1:PAGE_LSB];
    n++;
    t_fall = $realtime;
    on = 1'b1;
  end
  always @(negedge wr)
  begin
    if (on && $realtime - t_fall >= NOISE_NS) mem[wloc] = pins.byte_lane_out;
    on = 1'b0;
  end
endmodule : pwe_mem_model

// ---- test/page_write_eeprom_port_test.sv ----
`timescale 1ns/10ps
module page_write_eeprom_port_test;
  import pwe_pkg::*;
  localparam int LW = 200;
  localparam int PW = 300;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid = 1'b0;
  pwe_req_s req = '0;
  logic req_ready;
  logic rd_valid;
  logic page_open;
  logic po;
  logic [DATA_W-1:0] rd_data;
  logic [DATA_W-1:0] lanes;
  pwe_pins_s pins;
  int errs;
  int fails = 0;
  int checked = 0;
  always #2.5 mclk = ~mclk;
  pwe_host #(.LOAD_CYC_P(LW), .PROG_CYC_P(PW)) pwe_host_i (.mclk(mclk), .rst_b(rst_b),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .page_open(page_open), .pins(pins), .byte_lane_in(lanes));
  pwe_mem_model #(.WIN_NS(LW * CLK_NS), .PROG_NS(PW * CLK_NS)) pwe_mem_model_i (
    .pins(pins), .lanes(lanes), .errs(errs));
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask : check
  task automatic stop_test();
    $display("checked %0d, fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  // a request counts as taken at the edge where chip select falls
  task automatic send(input logic w, input logic [LOC_W-1:0] a, input logic [7:0] d);
    int k;
    logic prev;
    k = 0;
    @(negedge mclk);
    req_valid = 1'b1;
    req = '{w, a, d};
    do
    begin
      po = page_open;
      prev = pins.chip_sel_b;
      @(posedge mclk);
      #1;
      k++;
    end while (!(prev && !pins.chip_sel_b) && k < 3000);
    if (k >= 3000)
    begin
      check("request taken", 0, 1);
      stop_test();
    end
    check("ready after take", req_ready, 0);
    @(negedge mclk);
    req_valid = 1'b0;
  endtask : send
  task automatic rd(input logic [LOC_W-1:0] a, input logic [7:0] exp);
    int k;
    send(1'b0, a, 8'h00);
    check("open at read", po, 0);
    k = 0;
    while (rd_valid !== 1'b1 && k < 100)
    begin
      @(posedge mclk);
      #1;
      k++;
    end
    check("read cycles", k, READ_CYC);
    if (k >= 100)
      stop_test();
    check("read byte", rd_data, exp);
    @(negedge mclk);
  endtask : rd
  task automatic t_read();
    rd(17'h1FFFF, 8'h5A);
    rd(17'h00000, 8'hA5);
    $display("read test done");
  endtask : t_read
  task automatic t_page();
    for (int i = 0; i < 3; i++) send(1'b1, {9'h1AB, 8'(i * 127)}, 8'(i) ^ 8'h3C);
    check("page open", page_open, 1);
    for (int i = 0; i < 3; i++) rd({9'h1AB, 8'(i * 127)}, 8'(i) ^ 8'h3C);
    $display("page test done");
  endtask : t_page
  task automatic t_full();
    for (int i = 0; i < 256; i++) send(1'b1, {9'h002, 8'(i)}, 8'(i) ^ 8'h5A);
    send(1'b1, {9'h002, 8'h00}, 8'h11);
    check("byte 257 waits", po, 0);
    send(1'b1, {9'h003, 8'h10}, 8'h22);
    check("other page waits", po, 0);
    rd({9'h002, 8'h00}, 8'h11);
    rd({9'h002, 8'hFF}, 8'hA5);
    rd({9'h003, 8'h10}, 8'h22);
    $display("full page test done");
  endtask : t_full
  initial
  begin
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    rst_b = 1'b1;
    @(negedge mclk);
    t_read();
    t_page();
    t_full();
    check("memory faults", errs, 0);
    stop_test();
  end
endmodule : page_write_eeprom_port_test
